// File: shared/cbb_pkg.sv
// constants for the conditional bit branch executor
package cbb_pkg;
   localparam logic [7:0]  OP_BIT_CLR   = 8'h10;
   localparam logic [7:0]  OP_CARRY     = 8'h40;
   localparam logic [15:0] LEN_BIT_CLR  = 16'h0003;
   localparam logic [15:0] LEN_CARRY    = 16'h0002;
   localparam int          MACH_CYCLES  = 2;
   localparam logic [1:0]  CYC_LAST     = 2'h1;
   localparam logic [15:0] PC_RESET     = 16'h0000;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   typedef enum logic [2:0] {
      CBB_IDLE, CBB_OPER1, CBB_OPER2, CBB_EXEC, CBB_DONE
   } cbb_state_e;
endpackage : cbb_pkg

// File: rtl/cbb_rel_add.sv
// signed displacement adder for relative branch targets
`timescale 1ns/1ns
`default_nettype none
module cbb_rel_add (
   input  wire logic [15:0] pc_i,
   input  wire logic [7:0]  rel_i,
   output logic      [15:0] sum_o
);
   // wraps modulo 65536, reach -128..+127
   assign sum_o = pc_i + {{8{rel_i[7]}}, rel_i};
endmodule : cbb_rel_add
`default_nettype wire

// File: rtl/cbb_exec.sv
// decode and execution of the bit-clear branch and the carry branch
// What this block does
// - opcode 10h: bit test and clear branch, three bytes, two cycles.
// - pc advances by three; a set bit is cleared and offset added.
// - a clear bit is left alone and execution falls through.
// - third byte is a signed offset added to next-instruction pc.
// - port bits are read from the output latch, not the pin.
// - carry branch is taken only when carry equals one.
// - carry branch advances pc by two, then adds offset if taken.
// - opcode 40h: carry branch, two bytes, two cycles.
// - no status flag changes, taken or not.
`timescale 1ns/1ns
`default_nettype none
module cbb_exec (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   input  wire logic        start_i,
   input  wire logic [7:0]  opcode_i,
   input  wire logic [15:0] pc_i,
   input  wire logic        byte_vld_i,
   input  wire logic [7:0]  byte_i,
   input  wire logic        bit_vld_i,
   input  wire logic        bit_val_i,
   input  wire logic        carry_i,
   output logic             accept_o,
   output logic             fetch_req_o,
   output logic [15:0]      fetch_addr_o,
   output logic             bit_rd_o,
   output logic [7:0]       bit_addr_o,
   output logic             bit_clr_o,
   output logic             done_o,
   output logic             taken_o,
   output logic [15:0]      pc_o,
   output logic             cycle_o
);
   cbb_pkg::cbb_state_e state_ff;
   logic                is_bit_ff;
   logic [15:0]         pc_ff;
   logic [15:0]         next_pc_ff;
   logic [7:0]          baddr_ff;
   logic [7:0]          rel_ff;
   logic                cond_ff;
   logic                accept_ff;
   logic                fetch_req_ff;
   logic [15:0]         fetch_addr_ff;
   logic                bit_rd_ff;
   logic                bit_clr_ff;
   logic                done_ff;
   logic                taken_ff;
   logic [15:0]         pc_out_ff;
   logic                cycle_ff;
   logic [15:0]         target;
   logic                dec_bit;
   logic                dec_carry;

   assign dec_bit   = opcode_i == cbb_pkg::OP_BIT_CLR;
   assign dec_carry = opcode_i == cbb_pkg::OP_CARRY;

   cbb_rel_add u_add (
      .pc_i  (next_pc_ff),
      .rel_i (rel_ff),
      .sum_o (target)
   );

   // sequencer; fetch is byte by byte so no operand is consumed early
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_ff <= cbb_pkg::CBB_IDLE;
      end else if (ce_i) begin
         unique case (state_ff)
            cbb_pkg::CBB_IDLE:
               if (start_i && (dec_bit || dec_carry)) begin
                  state_ff <= cbb_pkg::CBB_OPER1;
               end
            cbb_pkg::CBB_OPER1:
               if (byte_vld_i) begin
                  state_ff <= is_bit_ff ? cbb_pkg::CBB_OPER2
                                        : cbb_pkg::CBB_EXEC;
               end
            cbb_pkg::CBB_OPER2:
               if (byte_vld_i) begin
                  state_ff <= cbb_pkg::CBB_EXEC;
               end
            cbb_pkg::CBB_EXEC:
               if (!is_bit_ff || bit_vld_i) begin
                  state_ff <= cbb_pkg::CBB_DONE;
               end
            cbb_pkg::CBB_DONE:
               state_ff <= cbb_pkg::CBB_IDLE;
            default:
               state_ff <= cbb_pkg::CBB_IDLE;
         endcase
      end
   end

   // operand capture and sequential pc
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         is_bit_ff  <= 1'b0;
         pc_ff      <= cbb_pkg::PC_RESET;
         next_pc_ff <= cbb_pkg::PC_RESET;
         baddr_ff   <= cbb_pkg::BYTE_RESET;
         rel_ff     <= cbb_pkg::BYTE_RESET;
      end else if (ce_i) begin
         if (state_ff == cbb_pkg::CBB_IDLE && start_i) begin
            is_bit_ff <= dec_bit;
            pc_ff     <= pc_i;
            if (dec_bit) begin
               next_pc_ff <= pc_i + cbb_pkg::LEN_BIT_CLR;
            end else begin
               next_pc_ff <= pc_i + cbb_pkg::LEN_CARRY;
            end
         end
         if (state_ff == cbb_pkg::CBB_OPER1 && byte_vld_i) begin
            if (is_bit_ff) begin
               baddr_ff <= byte_i;
            end else begin
               rel_ff <= byte_i;
            end
         end
         if (state_ff == cbb_pkg::CBB_OPER2 && byte_vld_i) begin
            rel_ff <= byte_i;
         end
      end
   end

   // condition: latch value for port bits comes from the bit source
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cond_ff <= 1'b0;
      end else if (ce_i && state_ff == cbb_pkg::CBB_EXEC) begin
         if (is_bit_ff) begin
            cond_ff <= bit_val_i;
         end else begin
            cond_ff <= carry_i;
         end
      end
   end

   // bus side outputs
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         accept_ff     <= 1'b0;
         fetch_req_ff  <= 1'b0;
         fetch_addr_ff <= cbb_pkg::PC_RESET;
         bit_rd_ff     <= 1'b0;
         bit_clr_ff    <= 1'b0;
      end else if (ce_i) begin
         accept_ff <= state_ff == cbb_pkg::CBB_IDLE && start_i
                      && (dec_bit || dec_carry);
         fetch_req_ff <= 1'b0;
         if (state_ff == cbb_pkg::CBB_IDLE && start_i
             && (dec_bit || dec_carry)) begin
            fetch_req_ff  <= 1'b1;
            fetch_addr_ff <= pc_i + 16'h0001;
         end else if (state_ff == cbb_pkg::CBB_OPER1 && byte_vld_i
                      && is_bit_ff) begin
            fetch_req_ff  <= 1'b1;
            fetch_addr_ff <= pc_ff + 16'h0002;
         end
         // bit read waits for the last operand; an answer that came
         // before exec would otherwise be lost and the sequencer hang
         bit_rd_ff <= (state_ff == cbb_pkg::CBB_OPER2 && byte_vld_i)
                      || (bit_rd_ff && !bit_vld_i);
         // clear only a set bit; a clear bit is left untouched
         bit_clr_ff <= state_ff == cbb_pkg::CBB_EXEC && is_bit_ff
                       && bit_vld_i && bit_val_i;
      end
   end

   // completion; no flag port exists, so flags cannot change
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         done_ff   <= 1'b0;
         taken_ff  <= 1'b0;
         pc_out_ff <= cbb_pkg::PC_RESET;
         cycle_ff  <= 1'b0;
      end else if (ce_i) begin
         done_ff <= state_ff == cbb_pkg::CBB_DONE;
         if (state_ff == cbb_pkg::CBB_DONE) begin
            taken_ff  <= cond_ff;
            pc_out_ff <= cond_ff ? target : next_pc_ff;
         end
         if (state_ff == cbb_pkg::CBB_IDLE) begin
            cycle_ff <= 1'b0;
         end else if (state_ff == cbb_pkg::CBB_EXEC) begin
            cycle_ff <= cbb_pkg::CYC_LAST[0];
         end
      end
   end

   assign accept_o     = accept_ff;
   assign fetch_req_o  = fetch_req_ff;
   assign fetch_addr_o = fetch_addr_ff;
   assign bit_rd_o     = bit_rd_ff;
   assign bit_addr_o   = baddr_ff;
   assign bit_clr_o    = bit_clr_ff;
   assign done_o       = done_ff;
   assign taken_o      = taken_ff;
   assign pc_o         = pc_out_ff;
   assign cycle_o      = cycle_ff;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   bit_clr_only_a: assert property (
      ce_i && bit_clr_o |-> $past(bit_val_i) && $past(is_bit_ff))
      else $error("bit cleared without being set");
   carry_taken_a: assert property (
      ce_i && $past(ce_i) && $past(ce_i,2) && done_o && !is_bit_ff
      |-> taken_o == $past(carry_i,2))
      else $error("carry branch decision wrong");
   bit_len_a: assert property (
      ce_i && accept_o && $past(dec_bit) |=>
      next_pc_ff == pc_ff + 16'h0003)
      else $error("bit branch pc not plus three");
   carry_len_a: assert property (
      ce_i && accept_o && $past(dec_carry) |=>
      next_pc_ff == pc_ff + 16'h0002)
      else $error("carry branch pc not plus two");
   target_calc_a: assert property (
      ce_i && done_o && taken_o |->
      pc_o == $past(next_pc_ff) + {{8{$past(rel_ff[7])}}, $past(rel_ff)})
      else $error("branch target wrong");
   fall_thru_a: assert property (
      ce_i && done_o && !taken_o |-> pc_o == $past(next_pc_ff))
      else $error("fall through pc wrong");
   bit_decode_a: assert property (
      ce_i && state_ff == cbb_pkg::CBB_IDLE && start_i
      && opcode_i == 8'h10 |=> accept_o && is_bit_ff)
      else $error("bit branch not decoded");
   carry_decode_a: assert property (
      ce_i && state_ff == cbb_pkg::CBB_IDLE && start_i
      && opcode_i == 8'h40 |=> accept_o && !is_bit_ff)
      else $error("carry branch not decoded");
   latch_src_a: assert property (
      ce_i && state_ff == cbb_pkg::CBB_EXEC && is_bit_ff && bit_vld_i
      |=> cond_ff == $past(bit_val_i))
      else $error("bit value not taken from source");
   no_clr_carry_a: assert property (
      !is_bit_ff |-> !bit_clr_o ##0 1)
      else $error("carry branch wrote a bit");

   cov_bit_taken: cover property (done_o && taken_o && is_bit_ff);
   cov_bit_fall: cover property (done_o && !taken_o && is_bit_ff);
   cov_carry_taken: cover property (done_o && taken_o && !is_bit_ff);
   cov_back_jump: cover property (done_o && taken_o && rel_ff[7]);
endmodule : cbb_exec
`default_nettype wire

// File: sim/cbb_pmem.sv
// program memory and bit space model facing the branch executor
`timescale 1ns/1ns
`default_nettype none
module cbb_pmem (
   input  wire logic        clk_i,
   input  wire logic [3:0]  wait_i,
   input  wire logic        fetch_req_i,
   input  wire logic [15:0] fetch_addr_i,
   input  wire logic        bit_rd_i,
   input  wire logic [7:0]  bit_addr_i,
   input  wire logic        bit_clr_i,
   output logic             byte_vld_o,
   output logic [7:0]       byte_o,
   output logic             bit_vld_o,
   output logic             bit_val_o
);
   logic [7:0]  mem [0:255];
   logic        bits [0:255];
   logic [15:0] addr_q = 16'h0000;
   int          cnt = 0;
   initial begin
      byte_vld_o = 1'b0;
      byte_o = 8'h00;
      bit_vld_o = 1'b0;
      bit_val_o = 1'b0;
      for (int i = 0; i < 256; i++) mem[i] = 8'h5a;
   end
   // idle data toggles so a stale byte never passes for a fresh one
   always @(posedge clk_i) begin
      byte_vld_o <= 1'b0;
      byte_o <= ~byte_o;
      if (fetch_req_i) begin
         addr_q = fetch_addr_i;
         cnt = int'(wait_i) + 1;
      end
      if (cnt == 1) begin
         byte_vld_o <= 1'b1;
         byte_o <= mem[addr_q[7:0]];
      end
      if (cnt != 0) cnt = cnt - 1;
   end
   always @(posedge clk_i) begin
      bit_vld_o <= bit_rd_i & ~bit_vld_o;
      bit_val_o <= bit_rd_i ? bits[bit_addr_i] : ~bit_val_o;
      if (bit_clr_i) bits[bit_addr_i] <= 1'b0;
   end
endmodule : cbb_pmem
`default_nettype wire

// File: sim/cbb_exec_tb.sv
// self-checking bench for the branch executor
`timescale 1ns/1ns
`default_nettype none
module cbb_exec_tb;
   logic clk_i = 0, sys_rst_i = 1, start = 0, carry = 0;
   logic [7:0] opcode = 8'h00;
   logic [15:0] pc_in = 16'h0000;
   logic [3:0] wt = 4'h0;
   logic bvld, bval, fch, brd, bclr, acc, done_o, tk, bvld_b, cyc;
   logic [7:0] byt, badr;
   logic [15:0] fadr, pc_o;
   int n_mismatch = 0, check_count = 0, cycles = 0, n_clr = 0;
   always #5 clk_i = ~clk_i;
   cbb_exec cbb_exec_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .start_i(start), .opcode_i(opcode), .pc_i(pc_in), .byte_vld_i(bvld),
      .byte_i(byt), .bit_vld_i(bvld_b), .bit_val_i(bval), .carry_i(carry),
      .accept_o(acc), .fetch_req_o(fch), .fetch_addr_o(fadr),
      .bit_rd_o(brd), .bit_addr_o(badr), .bit_clr_o(bclr), .done_o(done_o),
      .taken_o(tk), .pc_o(pc_o), .cycle_o(cyc));
   cbb_pmem cbb_pmem_i (.clk_i(clk_i), .wait_i(wt), .fetch_req_i(fch),
      .fetch_addr_i(fadr), .bit_rd_i(brd), .bit_addr_i(badr),
      .bit_clr_i(bclr), .byte_vld_o(bvld), .byte_o(byt),
      .bit_vld_o(bvld_b), .bit_val_o(bval));
   task automatic print_verdict();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string w, input logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   // expected target worked out from the branch length and offset
   function automatic logic [15:0] tgt(logic [15:0] pc, logic [15:0] len,
                                       logic [7:0] rel, logic t);
      return pc + len + (t ? {{8{rel[7]}}, rel} : 16'h0000);
   endfunction : tgt
   task automatic run_op(input logic [7:0] op, logic [15:0] pc,
                         logic [7:0] b1, logic [7:0] b2, logic bv);
      int n;
      n = 0;
      cbb_pmem_i.mem[pc[7:0] + 8'h01] = b1;
      cbb_pmem_i.mem[pc[7:0] + 8'h02] = b2;
      cbb_pmem_i.bits[b1] = bv;
      n_clr = 0;
      @(negedge clk_i);
      start = 1;
      opcode = op;
      pc_in = pc;
      @(negedge clk_i);
      start = 0;
      chk("accept", 16'h1, {15'h0, acc});
      while (done_o !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n_clr += int'(bclr === 1'b1);
         n++;
      end
      chk("done", 16'h1, {15'h0, done_o});
      chk("cycle", 16'h1, {15'h0, cyc});
   endtask : run_op
   task automatic sc_bit_set();
      run_op(cbb_pkg::OP_BIT_CLR, 16'h0000, 8'h25, 8'h80, 1'b1);
      chk("taken", 16'h1, {15'h0, tk});
      chk("pc", tgt(16'h0000, cbb_pkg::LEN_BIT_CLR, 8'h80, 1), pc_o);
      chk("clears", 16'h1, 16'(n_clr));
      chk("bit", 16'h0, {15'h0, cbb_pmem_i.bits[8'h25]});
   endtask : sc_bit_set
   task automatic sc_bit_zero();
      run_op(cbb_pkg::OP_BIT_CLR, 16'h1234, 8'h33, 8'h10, 1'b0);
      chk("taken", 16'h0, {15'h0, tk});
      chk("pc", tgt(16'h1234, cbb_pkg::LEN_BIT_CLR, 8'h10, 0), pc_o);
      chk("clears", 16'h0, 16'(n_clr));
   endtask : sc_bit_zero
   task automatic sc_carry(input logic c, logic [15:0] pc, logic [7:0] r);
      carry = c;
      run_op(cbb_pkg::OP_CARRY, pc, r, 8'h00, 1'b0);
      chk("taken", {15'h0, c}, {15'h0, tk});
      chk("pc", tgt(pc, cbb_pkg::LEN_CARRY, r, c), pc_o);
   endtask : sc_carry
   task automatic sc_ignore();
      int a;
      a = 0;
      @(negedge clk_i);
      start = 1;
      opcode = 8'h20;
      repeat (6) begin
         @(negedge clk_i);
         a += int'(acc !== 1'b0 || fch !== 1'b0);
      end
      start = 0;
      chk("foreign opcode", 16'h0, 16'(a));
   endtask : sc_ignore
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(negedge clk_i);
      sys_rst_i = 0;
      sc_bit_set();
      sc_bit_zero();
      wt = 4'h3;
      sc_carry(1'b1, 16'hfffe, 8'h7f);
      wt = 4'h0;
      sc_carry(1'b0, 16'h0200, 8'h80);
      sc_ignore();
      print_verdict();
   end
endmodule : cbb_exec_tb
`default_nettype wire
